// file: cilc_ext_model.sv
`timescale 1ns/1ps
module cilc_ext_model #(
  parameter int unsigned NUM_LINES = 2
) (
  input  wire logic                 pclk,
  output logic      [NUM_LINES-1:0] line_in,
  output logic                      frame_active,
  output logic                      row_active,
  output logic                      exposure_begin_event
);
  initial
  begin
    line_in = '0;
    frame_active = 1'b0;
    row_active = 1'b0;
    exposure_begin_event = 1'b0;
  end
  // Short holds model contact bounce
  task automatic hold(input int unsigned idx, input logic v, input int unsigned n);
    line_in[idx] <= v;
    repeat (n) @(posedge pclk);
  endtask : hold
  // One high cycle: one rise, one exposure event
  task automatic fire(input logic [2:0] src);
    @(posedge pclk);
    frame_active <= (src == cilc_pkg::SRC_FRAME);
    row_active <= (src == cilc_pkg::SRC_ROW);
    exposure_begin_event <= (src == cilc_pkg::SRC_EXPO);
    @(posedge pclk);
    frame_active <= 1'b0;
    row_active <= 1'b0;
    exposure_begin_event <= 1'b0;
  endtask : fire
endmodule : cilc_ext_model

// file: cilc_glitch_filter.sv
`timescale 1ns/1ps
module cilc_glitch_filter #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             level_i,
  input  wire logic [CNT_W-1:0] period_i,
  output logic                  level_o
);

  logic [CNT_W-1:0] cnt_reg;
  wire              differs = level_i != level_o;
  wire              ripe    = cnt_reg >= period_i;

  // Any return to the old level restarts the wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
      level_o <= 1'b0;
    end
    else if (!differs)
      cnt_reg <= '0;
    else if (ripe)
    begin
      level_o <= level_i;
      cnt_reg <= '0;
    end
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

endmodule : cilc_glitch_filter

// file: cilc_pkg.sv
package cilc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W  = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_FILTER = 8'h0C;
  localparam logic [7:0] OFS_PWIDTH = 8'h10;
  localparam logic [7:0] OFS_PDELAY = 8'h14;

  // Field positions
  localparam int unsigned STS_DIR_BIT   = 0;
  localparam int unsigned STS_LVL_BIT   = 1;
  localparam int unsigned CFG_THR_LSB   = 0;
  localparam int unsigned CFG_INV_BIT   = 2;
  localparam int unsigned CFG_TERM_BIT  = 3;
  localparam int unsigned CFG_SRC_LSB   = 4;
  localparam int unsigned CFG_SWLVL_BIT = 7;

  // Output source codes
  localparam logic [2:0] SRC_OFF   = 3'h0;
  localparam logic [2:0] SRC_SW    = 3'h1;
  localparam logic [2:0] SRC_FRAME = 3'h2;
  localparam logic [2:0] SRC_ROW   = 3'h3;
  localparam logic [2:0] SRC_EXPO  = 3'h4;

  // Threshold codes: 1.5V, 2.5V, 5.0V, 5.0V
  localparam logic [1:0] THR_LOW_VOLT  = 2'h0;
  localparam logic [1:0] THR_TTL       = 2'h1;
  localparam logic [1:0] THR_MID_VOLT  = 2'h2;
  localparam logic [1:0] THR_HIGH_VOLT = 2'h3;

  // Reset values
  localparam logic [15:0] RST_FILTER = 16'h0000;
  localparam logic [15:0] RST_PWIDTH = 16'h0001;
  localparam logic [15:0] RST_PDELAY = 16'h0000;

  typedef logic [CNT_W-1:0] cilc_count_t;

  typedef struct packed {
    logic [1:0]  thr;
    logic        inv;
    logic        term;
    logic [2:0]  src;
    logic        swlvl;
    cilc_count_t filt;
    cilc_count_t pwidth;
    cilc_count_t pdelay;
  } cilc_line_cfg_s;

  localparam cilc_line_cfg_s CFG_RESET = '{
    thr:    THR_LOW_VOLT,
    inv:    1'b0,
    term:   1'b0,
    src:    SRC_OFF,
    swlvl:  1'b0,
    filt:   RST_FILTER,
    pwidth: RST_PWIDTH,
    pdelay: RST_PDELAY
  };

endpackage : cilc_pkg

// file: cilc_pulse_gen.sv
`timescale 1ns/1ps
module cilc_pulse_gen #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             trig_i,
  input  wire logic [CNT_W-1:0] delay_i,
  input  wire logic [CNT_W-1:0] width_i,
  output logic                  pulse_o
);

  typedef enum logic [1:0] {CILC_IDLE, CILC_WAIT, CILC_HIGH} cilc_pstate_e;

  cilc_pstate_e     st_reg;
  logic [CNT_W-1:0] cnt_reg;
  wire              no_delay = delay_i == '0;
  wire              no_width = width_i == '0;
  wire              cnt_done = cnt_reg == '0;

  // Triggers while busy are dropped, not queued
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg  <= CILC_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      unique case (st_reg)
        CILC_IDLE:
          if (trig_i && !no_delay)
          begin
            st_reg  <= CILC_WAIT;
            cnt_reg <= delay_i - 1'b1;
          end
          else if (trig_i && !no_width)
          begin
            st_reg  <= CILC_HIGH;
            cnt_reg <= width_i - 1'b1;
          end
        CILC_WAIT:
          if (!cnt_done)
            cnt_reg <= cnt_reg - 1'b1;
          else if (no_width)
            st_reg <= CILC_IDLE;
          else
          begin
            st_reg  <= CILC_HIGH;
            cnt_reg <= width_i - 1'b1;
          end
        CILC_HIGH:
          if (cnt_done)
            st_reg <= CILC_IDLE;
          else
            cnt_reg <= cnt_reg - 1'b1;
        default:
          st_reg <= CILC_IDLE;
      endcase
    end
  end

  assign pulse_o = st_reg == CILC_HIGH;

endmodule : cilc_pulse_gen

// file: cilc_top.sv
`timescale 1ns/1ps
// Functional notes
// - A line index register picks which line every per-line access touches.
// - Status shows read-only whether the selected line is input or output.
// - Per-line threshold choice drives that line's comparator select output.
// - Status shows the selected line's present logic level, input or output.
// - Per-line invert flag flips the input or output signal of that line.
// - Input change accepted only after persisting the programmed filter period.
// - Per-line termination flag drives that line's termination switch.
// - Per-line source picks off, software level or an event pulse to drive.
// - Source off leaves the output line undriven and open.
// - Software source drives the stored software level and follows changes.
// - Frame source emits one pulse at each rise of frame active that finds the pulse generator idle.
// - Row source emits one pulse at each rise of row active that finds the pulse generator idle.
// - Exposure source emits one pulse per exposure begin event that finds the pulse generator idle.
module cilc_top #(
  parameter int unsigned          NUM_LINES      = 2,
  parameter logic [NUM_LINES-1:0] LINE_IS_OUTPUT = 2'b10
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [cilc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cilc_pkg::DATA_W-1:0]   pwdata,
  output logic      [cilc_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [NUM_LINES-1:0]          line_in,
  output logic      [NUM_LINES-1:0]          line_out,
  output logic      [NUM_LINES-1:0]          line_oe_n,
  output logic      [NUM_LINES-1:0][1:0]     input_threshold_select,
  output logic      [NUM_LINES-1:0]          termination_enable,
  input  wire logic                          frame_active,
  input  wire logic                          row_active,
  input  wire logic                          exposure_begin_event
);

  localparam int unsigned IDX_W = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;

  if (NUM_LINES < 1 || NUM_LINES > 256)
  begin : g_bad_lines
    $error("NUM_LINES must lie in 1..256");
  end

  function automatic logic cilc_mapped(input logic [cilc_pkg::ADDR_W-1:0] a);
    cilc_mapped = (a == cilc_pkg::OFS_SELECT) || (a == cilc_pkg::OFS_STATUS) ||
                  (a == cilc_pkg::OFS_CONFIG) || (a == cilc_pkg::OFS_FILTER) ||
                  (a == cilc_pkg::OFS_PWIDTH) || (a == cilc_pkg::OFS_PDELAY);
  endfunction : cilc_mapped

  cilc_pkg::cilc_line_cfg_s cfg_reg [NUM_LINES];
  logic [IDX_W-1:0]         sel_reg;
  logic                     frame_d_reg;
  logic                     row_d_reg;
  logic [NUM_LINES-1:0]     filt_lvl;
  logic [NUM_LINES-1:0]     pulse;
  logic [NUM_LINES-1:0]     trig;
  logic [NUM_LINES-1:0]     drive_en;
  logic [NUM_LINES-1:0]     drive_lvl;
  logic [NUM_LINES-1:0]     line_state;

  // APB: one wait state so read data comes from a flop
  wire answer   = psel & penable & ~pready;
  wire commit   = psel & penable & pready;
  wire mapped   = cilc_mapped(paddr);
  wire hit_sel  = paddr == cilc_pkg::OFS_SELECT;
  wire hit_sts  = paddr == cilc_pkg::OFS_STATUS;
  wire hit_cfg  = paddr == cilc_pkg::OFS_CONFIG;
  wire hit_flt  = paddr == cilc_pkg::OFS_FILTER;
  wire hit_pw   = paddr == cilc_pkg::OFS_PWIDTH;
  wire hit_pd   = paddr == cilc_pkg::OFS_PDELAY;
  wire sel_bad  = pwdata >= NUM_LINES;
  // Status is read-only; writes to it and out-of-range indexes are refused
  wire wr_error = pwrite & (hit_sts | (hit_sel & sel_bad));
  wire err      = ~mapped | wr_error;
  wire wr_ok    = commit & pwrite & ~err;

  cilc_pkg::cilc_line_cfg_s cur;
  assign cur = cfg_reg[sel_reg];

  wire [cilc_pkg::DATA_W-1:0] rd_sel = {{(cilc_pkg::DATA_W-IDX_W){1'b0}}, sel_reg};
  wire [cilc_pkg::DATA_W-1:0] rd_sts =
    ({{(cilc_pkg::DATA_W-1){1'b0}}, LINE_IS_OUTPUT[sel_reg]} << cilc_pkg::STS_DIR_BIT) |
    ({{(cilc_pkg::DATA_W-1){1'b0}}, line_state[sel_reg]} << cilc_pkg::STS_LVL_BIT);
  wire [cilc_pkg::DATA_W-1:0] rd_cfg =
    ({{(cilc_pkg::DATA_W-2){1'b0}}, cur.thr} << cilc_pkg::CFG_THR_LSB) |
    ({{(cilc_pkg::DATA_W-1){1'b0}}, cur.inv} << cilc_pkg::CFG_INV_BIT) |
    ({{(cilc_pkg::DATA_W-1){1'b0}}, cur.term} << cilc_pkg::CFG_TERM_BIT) |
    ({{(cilc_pkg::DATA_W-3){1'b0}}, cur.src} << cilc_pkg::CFG_SRC_LSB) |
    ({{(cilc_pkg::DATA_W-1){1'b0}}, cur.swlvl} << cilc_pkg::CFG_SWLVL_BIT);
  wire [cilc_pkg::DATA_W-1:0] rd_flt = {{(cilc_pkg::DATA_W-cilc_pkg::CNT_W){1'b0}}, cur.filt};
  wire [cilc_pkg::DATA_W-1:0] rd_pw  = {{(cilc_pkg::DATA_W-cilc_pkg::CNT_W){1'b0}}, cur.pwidth};
  wire [cilc_pkg::DATA_W-1:0] rd_pd  = {{(cilc_pkg::DATA_W-cilc_pkg::CNT_W){1'b0}}, cur.pdelay};
  wire [cilc_pkg::DATA_W-1:0] rd_mux =
    hit_sel ? rd_sel :
    hit_sts ? rd_sts :
    hit_cfg ? rd_cfg :
    hit_flt ? rd_flt :
    hit_pw  ? rd_pw  :
    hit_pd  ? rd_pd  : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= answer;
      pslverr <= answer & err;
      if (answer)
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_reg <= '0;
    else if (wr_ok && hit_sel)
      sel_reg <= pwdata[IDX_W-1:0];
  end

  // Config fields land only in the selected line's slot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_LINES; i++)
        cfg_reg[i] <= cilc_pkg::CFG_RESET;
    end
    else if (wr_ok)
    begin
      if (hit_cfg)
      begin
        cfg_reg[sel_reg].thr   <= pwdata[cilc_pkg::CFG_THR_LSB +: 2];
        cfg_reg[sel_reg].inv   <= pwdata[cilc_pkg::CFG_INV_BIT];
        cfg_reg[sel_reg].term  <= pwdata[cilc_pkg::CFG_TERM_BIT];
        cfg_reg[sel_reg].src   <= pwdata[cilc_pkg::CFG_SRC_LSB +: 3];
        cfg_reg[sel_reg].swlvl <= pwdata[cilc_pkg::CFG_SWLVL_BIT];
      end
      if (hit_flt)
        cfg_reg[sel_reg].filt <= pwdata[cilc_pkg::CNT_W-1:0];
      if (hit_pw)
        cfg_reg[sel_reg].pwidth <= pwdata[cilc_pkg::CNT_W-1:0];
      if (hit_pd)
        cfg_reg[sel_reg].pdelay <= pwdata[cilc_pkg::CNT_W-1:0];
    end
  end

  // Start edges of the level-type camera events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_d_reg <= 1'b0;
      row_d_reg   <= 1'b0;
    end
    else
    begin
      frame_d_reg <= frame_active;
      row_d_reg   <= row_active;
    end
  end

  wire frame_rise = frame_active & ~frame_d_reg;
  wire row_rise   = row_active & ~row_d_reg;

  for (genvar i = 0; i < NUM_LINES; i++)
  begin : g_line
    wire [2:0] src    = cfg_reg[i].src;
    wire       is_out = LINE_IS_OUTPUT[i];

    cilc_glitch_filter #(
      .CNT_W    (cilc_pkg::CNT_W)
    ) u_filter (
      .pclk     (pclk),
      .presetn  (presetn),
      .level_i  (line_in[i]),
      .period_i (cfg_reg[i].filt),
      .level_o  (filt_lvl[i])
    );

    // Input lines never see triggers, so their pulse stays low
    assign trig[i] = is_out & (
                     (src == cilc_pkg::SRC_FRAME & frame_rise) |
                     (src == cilc_pkg::SRC_ROW   & row_rise)   |
                     (src == cilc_pkg::SRC_EXPO  & exposure_begin_event));

    cilc_pulse_gen #(
      .CNT_W    (cilc_pkg::CNT_W)
    ) u_pulse (
      .pclk     (pclk),
      .presetn  (presetn),
      .trig_i   (trig[i]),
      .delay_i  (cfg_reg[i].pdelay),
      .width_i  (cfg_reg[i].pwidth),
      .pulse_o  (pulse[i])
    );

    assign drive_en[i]  = is_out & (src != cilc_pkg::SRC_OFF);
    // Inverter sits after pulse shaping, so delay and width are kept
    assign drive_lvl[i] = ((src == cilc_pkg::SRC_SW) ? cfg_reg[i].swlvl
                                                     : pulse[i]) ^ cfg_reg[i].inv;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        line_out[i]  <= 1'b0;
        line_oe_n[i] <= 1'b1;
      end
      else
      begin
        line_out[i]  <= drive_en[i] & drive_lvl[i];
        line_oe_n[i] <= ~drive_en[i];
      end
    end

    // Output lines report the driven pin level, inputs the filtered level after the invert flag
    assign line_state[i] = is_out ? line_out[i]
                                  : filt_lvl[i] ^ cfg_reg[i].inv;

    assign input_threshold_select[i] = cfg_reg[i].thr;
    assign termination_enable[i]     = cfg_reg[i].term;
  end

endmodule : cilc_top

// file: cilc_top_asserts.sv
`timescale 1ns/1ps
module cilc_top_asserts #(
  parameter int unsigned          NUM_LINES      = 2,
  parameter logic [NUM_LINES-1:0] LINE_IS_OUTPUT = 2'b10
) (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [cilc_pkg::DATA_W-1:0]   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic [NUM_LINES-1:0]          line_out,
  input wire logic [NUM_LINES-1:0]          line_oe_n,
  input wire logic [NUM_LINES-1:0][1:0]     input_threshold_select,
  input wire logic [NUM_LINES-1:0]          termination_enable
);
  logic wr;
  assign wr = pready && pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_timing: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> s_access and $past(psel && penable))
    else $error("pready without access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("refused read returned data");
  a_input_no_drive: assert property (&(line_oe_n | LINE_IS_OUTPUT))
    else $error("input line driven");
  a_open_is_low: assert property ((line_out & line_oe_n) == '0)
    else $error("undriven line shows high");
  a_oe_cause: assert property ($changed(line_oe_n) |->
    $past(wr, 1) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("drive enable changed without write");
  a_cfg_cause: assert property ($changed({input_threshold_select, termination_enable}) |->
    $past(wr, 1) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("threshold or termination changed without write");
endmodule : cilc_top_asserts

bind cilc_top cilc_top_asserts #(.NUM_LINES(NUM_LINES), .LINE_IS_OUTPUT(LINE_IS_OUTPUT)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_out(line_out), .line_oe_n(line_oe_n),
  .input_threshold_select(input_threshold_select), .termination_enable(termination_enable));

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} cilc_note_s;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic [7:0]      paddr = '0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [31:0]     pwdata = '0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [1:0]      line_in;
  logic [1:0]      line_out;
  logic [1:0]      line_oe_n;
  logic [1:0][1:0] thr_sel;
  logic [1:0]      term_en;
  logic            frame_active;
  logic            row_active;
  logic            expo_evt;
  logic [31:0]     seed = 32'h0000_000C;
  cilc_note_s      q[$];
  int              n_errors = 0;
  int              n_compared = 0;

  always #5 pclk = ~pclk;

  cilc_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n), .input_threshold_select(thr_sel),
    .termination_enable(term_en), .frame_active(frame_active), .row_active(row_active),
    .exposure_begin_event(expo_evt));
  cilc_ext_model i_ext (.pclk(pclk), .line_in(line_in), .frame_active(frame_active),
    .row_active(row_active), .exposure_begin_event(expo_evt));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [7:0] cfg(logic [1:0] t, logic inv, logic term, logic [2:0] s, logic sw);
    return {sw, s, term, inv, t};
  endfunction : cfg

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Writes must read back zero on prdata as well
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ed,
                     input logic ee);
    int t;
    t = 0;
    q.push_back('{ed, 32'hFFFF_FFFF, ee});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 20)
    begin
      @(posedge pclk);
      t++;
    end
    if (t == 20)
      n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic pin(input logic o, input logic oe_n);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(line_out[1]), 32'(o));
    chk(32'(line_oe_n[1]), 32'(oe_n));
    @(posedge pclk);
  endtask : pin

  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      cilc_note_s n;
      n = q.pop_front();
      chk(prdata & n.m, n.d);
      chk(32'(pslverr), 32'(n.e));
    end

  task automatic conclude();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #100us;
    n_errors++;
    conclude();
  end

  initial
  begin
    logic [31:0] r;
    logic [7:0]  c;
    int          cnt;
    int          first;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++)
      apb(1'b0, 8'(i * 4), '0, (i == 4) ? 32'h0000_0001 : 32'h0000_0000, 1'b0);
    apb(1'b0, 8'h18, '0, '0, 1'b1);
    apb(1'b1, cilc_pkg::OFS_STATUS, 32'h0000_0003, '0, 1'b1);
    apb(1'b1, cilc_pkg::OFS_SELECT, 32'h0000_0002, '0, 1'b1);
    apb(1'b0, cilc_pkg::OFS_SELECT, '0, '0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      c = cfg(2'(i), 1'b0, i[0], cilc_pkg::SRC_OFF, 1'b0);
      apb(1'b1, cilc_pkg::OFS_CONFIG, {r[31:8], c}, '0, 1'b0);
      apb(1'b0, cilc_pkg::OFS_CONFIG, '0, {24'h00_0000, c}, 1'b0);
      chk(32'(thr_sel[0]), 32'(i));
      chk(32'(term_en[0]), 32'(i[0]));
    end
    apb(1'b1, cilc_pkg::OFS_FILTER, 32'h0000_0003, '0, 1'b0);
    i_ext.hold(0, 1'b1, 3);
    i_ext.hold(0, 1'b0, 2);
    apb(1'b0, cilc_pkg::OFS_STATUS, '0, 32'h0000_0000, 1'b0);
    i_ext.hold(0, 1'b1, 6);
    apb(1'b0, cilc_pkg::OFS_STATUS, '0, 32'h0000_0002, 1'b0);
    apb(1'b1, cilc_pkg::OFS_CONFIG, 32'(cfg(2'h3, 1'b1, 1'b1, cilc_pkg::SRC_OFF, 1'b0)), '0, 1'b0);
    apb(1'b0, cilc_pkg::OFS_STATUS, '0, 32'h0000_0000, 1'b0);
    // Output line is selected before any source is set
    apb(1'b1, cilc_pkg::OFS_SELECT, 32'h0000_0001, '0, 1'b0);
    apb(1'b0, cilc_pkg::OFS_STATUS, '0, 32'h0000_0001, 1'b0);
    for (int v = 0; v < 4; v++)
    begin
      r = xs();
      apb(1'b1, cilc_pkg::OFS_CONFIG, 32'(cfg(2'h0, v[1], 1'b0, cilc_pkg::SRC_SW, r[0])), '0, 1'b0);
      pin(r[0] ^ v[1], 1'b0);
      apb(1'b0, cilc_pkg::OFS_STATUS, '0, {30'h0, r[0] ^ v[1], 1'b1}, 1'b0);
    end
    apb(1'b1, cilc_pkg::OFS_CONFIG, 32'(cfg(2'h0, 1'b1, 1'b0, cilc_pkg::SRC_OFF, 1'b1)), '0, 1'b0);
    pin(1'b0, 1'b1);
    apb(1'b1, cilc_pkg::OFS_PWIDTH, 32'h0000_0003, '0, 1'b0);
    apb(1'b1, cilc_pkg::OFS_PDELAY, 32'h0000_0002, '0, 1'b0);
    for (int s = 2; s < 5; s++)
      for (int v = 0; v < 2; v++)
      begin
        apb(1'b1, cilc_pkg::OFS_CONFIG, 32'(cfg(2'h0, v[0], 1'b0, 3'(s), 1'b0)), '0, 1'b0);
        repeat (3) @(posedge pclk);
        i_ext.fire(3'(s));
        cnt = 0;
        first = 0;
        for (int k = 1; k < 15; k++)
        begin
          @(posedge pclk);
          #1;
          if ((line_out[1] ^ v[0]) === 1'b1)
          begin
            cnt++;
            if (first == 0)
              first = k;
          end
        end
        chk(32'(cnt), 32'h0000_0003);
        chk(32'(first), 32'h0000_0003);
        @(posedge pclk);
      end
    conclude();
  end
endmodule : tb_top
